/* hdl/crm_pkg.sv */
// Constants, modes and carriers for the alternating-reload and retrigger counter.
// Assumes a single system clock; all inputs synchronous to it.
package crm_pkg;
    // =========================================================
    // Register map
    localparam logic [3:0] CRM_ADDR_MODE = 4'h0;
    localparam logic [3:0] CRM_ADDR_LOAD = 4'h1;
    localparam logic [3:0] CRM_ADDR_HOLD = 4'h2;
    localparam logic [3:0] CRM_ADDR_CMD = 4'h3;
    localparam logic [3:0] CRM_ADDR_STAT = 4'h4;
    localparam logic [3:0] CRM_ADDR_CNT = 4'h5;
    // =========================================================
    // Mode register fields
    localparam int CRM_GATE_LSB = 13;
    localparam int CRM_OP_LSB = 5;
    localparam int CRM_UP_BIT = 3;
    localparam int CRM_TGL_BIT = 0;
    localparam logic [15:0] CRM_MODE_RESET = 16'h0800;
    localparam logic [2:0] CRM_GATE_NONE = 3'h0;
    localparam logic [2:0] CRM_GATE_LVL_HI = 3'h5;
    localparam logic [2:0] CRM_GATE_LVL_LO = 3'h4;
    localparam logic [2:0] CRM_GATE_EDGE_HI = 3'h6;
    localparam logic [2:0] CRM_GATE_EDGE_LO = 3'h7;
    localparam logic [15:0] CRM_DOWN_LAST = 16'h0001;
    localparam logic [15:0] CRM_UP_LAST = 16'hffff;
    // Command bits
    localparam int CRM_CMD_ARM = 0;
    localparam int CRM_CMD_DISARM = 1;
    localparam int CRM_CMD_LOAD = 2;
    typedef enum logic [2:0] {
        CRM_OP_ALT = 3'b011,
        CRM_OP_STROBE = 3'b100,
        CRM_OP_SYNC = 3'b101
    } crm_op_type;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } crm_bus_type;
    typedef struct packed {
        logic src;
        logic gate;
    } crm_pins_type;
endpackage

/* hdl/crm_edge.sv */
// Edge detector for the source and gate pins.
// Assumes pins already synchronous to clk_sys.
`timescale 1ns/10ps
module crm_edge (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Pins
    input wire crm_pkg::crm_pins_type pins,
    // Events and gate level
    output logic src_rise,
    output logic gate_rise,
    output logic gate_fall,
    output logic gate_lvl
);
    import crm_pkg::*;
    logic src_q;
    logic gate_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            src_q <= pins.src;
            gate_q <= pins.gate;
        end
    end
    assign src_rise = pins.src & ~src_q;
    assign gate_rise = pins.gate & ~gate_q;
    assign gate_fall = ~pins.gate & gate_q;
    assign gate_lvl = pins.gate;
endmodule

/* hdl/crm_counter.sv */
// What this block does
// RULE_01 - Gate field zero: gate ignored entirely
// RULE_02 - Alternating mode runs until disarm
// RULE_03 - Reload alternates Hold then Load
// RULE_04 - Toggle output widths from Load, Hold
// RULE_05 - Level gate: count only gated edges
// RULE_06 - Level gate: first reload after arm Hold
// RULE_07 - Edge mode: armed gate edge starts count
// RULE_08 - Edge mode: gate ignored during cycle
// RULE_09 - Edge alternating: two reloads, halt, rearm-free
// RULE_10 - Gate edges ignored while disarmed
// RULE_11 - Level strobe: reload Load, disarm
// RULE_12 - Level strobe: gate edge saves count
// RULE_13 - Retrigger: load then resume counting
// RULE_14 - Qualified edge: source rise, gate active
// RULE_15 - Edge strobe: count all, reload, disarm
// RULE_16 - Arm first, then gate edge
// RULE_17 - Edge strobe: every edge retriggers
// RULE_18 - Edge retrigger: load, then resume
// RULE_19 - Sync rate: reload Load every terminal
// RULE_20 - Sync rate: gate edge saves, reloads
// RULE_21 - One-shot: count all, reload, halt
// RULE_22 - One-shot: every edge saves and reloads
// RULE_23 - Terminal after 0001 down, ffff up
// RULE_24 - Host writes mode only when disarmed
// RULE_25 - Gate sampled with source edge
// Counter modes J, K, L, N, O, Q, R over a plain register port.
// Assumes host keeps strobes one cycle and mode writes while disarmed.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module crm_counter (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire crm_pkg::crm_bus_type bus,
    output logic [15:0] rdata,
    // Pins
    input wire crm_pkg::crm_pins_type pins,
    output logic out_pin,
    output logic terminal_count,
    output logic armed
);
    import crm_pkg::*;

    // =========================================================
    // Registers
    logic [15:0] mode_q;
    logic [15:0] load_q;
    logic [15:0] hold_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] hold_d;
    logic armed_q;
    logic armed_d;
    logic run_q;
    logic run_d;
    logic second_q;
    logic second_d;
    logic retrig_q;
    logic retrig_d;
    logic tgl_q;
    logic tc_q;
    logic out_q;
    logic [15:0] rdata_q;
    logic src_rise;
    logic gate_rise;
    logic gate_fall;
    logic gate_lvl;

    crm_edge u_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pins(pins),
        .src_rise(src_rise),
        .gate_rise(gate_rise),
        .gate_fall(gate_fall),
        .gate_lvl(gate_lvl)
    );

    function automatic logic is_last(input logic [15:0] v, input logic up);
        is_last = up ? (v == CRM_UP_LAST) : (v == CRM_DOWN_LAST);
    endfunction

    // =========================================================
    // Mode decode
    wire [2:0] gate_sel = mode_q[CRM_GATE_LSB +: 3];
    wire [2:0] op_sel = mode_q[CRM_OP_LSB +: 3];
    wire count_up = mode_q[CRM_UP_BIT];
    wire tgl_sel = mode_q[CRM_TGL_BIT];
    wire gate_none = (gate_sel == CRM_GATE_NONE); // RULE_01
    wire gate_level = (gate_sel == CRM_GATE_LVL_HI) || (gate_sel == CRM_GATE_LVL_LO);
    wire gate_edge = (gate_sel == CRM_GATE_EDGE_HI) || (gate_sel == CRM_GATE_EDGE_LO);
    wire gate_pol_lo = (gate_sel == CRM_GATE_LVL_LO) || (gate_sel == CRM_GATE_EDGE_LO);
    wire gate_act = gate_pol_lo ? ~gate_lvl : gate_lvl;
    wire gate_go = gate_pol_lo ? gate_fall : gate_rise;
    wire op_alt = (op_sel == CRM_OP_ALT);
    wire op_strobe = (op_sel == CRM_OP_STROBE);
    wire op_sync = (op_sel == CRM_OP_SYNC);
    wire retrig_mode = op_strobe || op_sync;

    // =========================================================
    // Commands
    wire cmd_wr = bus.wr && (bus.addr == CRM_ADDR_CMD);
    wire cmd_arm = cmd_wr && bus.wdata[CRM_CMD_ARM];
    wire cmd_disarm = cmd_wr && bus.wdata[CRM_CMD_DISARM];
    wire cmd_load = cmd_wr && bus.wdata[CRM_CMD_LOAD];

    // =========================================================
    // Counting qualification
    wire qual_src = src_rise && (gate_level ? gate_act : 1'b1); // RULE_14 RULE_25 RULE_05
    wire edge_start = armed_q && gate_edge && gate_go; // RULE_10 RULE_16
    wire trigger = edge_start && (!run_q || retrig_mode); // RULE_08 RULE_17
    wire level_retrig = armed_q && gate_level && retrig_mode && gate_go; // RULE_12 RULE_20
    wire retrig_ev = level_retrig || (trigger && retrig_mode); // RULE_22
    wire may_count = armed_q && (gate_edge ? run_q : 1'b1); // RULE_07
    wire step = may_count && qual_src && !retrig_ev;
    wire at_tc = step && !retrig_q && is_last(cnt_q, count_up); // RULE_23
    wire alt_hold = op_alt && !second_q; // RULE_03

    always_comb begin
        cnt_d = cnt_q;
        hold_d = hold_q;
        armed_d = armed_q;
        run_d = run_q;
        second_d = second_q;
        retrig_d = retrig_q;
        if (retrig_ev) begin
            hold_d = cnt_q;
            retrig_d = 1'b1;
        end
        if (trigger) begin
            run_d = 1'b1;
        end
        if (step && retrig_q) begin
            cnt_d = load_q; // RULE_13 RULE_18
            retrig_d = 1'b0;
        end else if (at_tc) begin
            cnt_d = alt_hold ? hold_q : load_q; // RULE_19
            second_d = op_alt ? !second_q : 1'b0; // RULE_02
            if (op_strobe) begin
                armed_d = 1'b0; // RULE_11 RULE_15
                run_d = 1'b0;
            end else if (gate_edge && (!op_alt || second_q)) begin
                run_d = 1'b0; // RULE_09 RULE_21
            end
        end else if (step) begin
            cnt_d = count_up ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
        end
        if (cmd_load) begin
            cnt_d = load_q;
        end
        if (cmd_arm) begin
            armed_d = 1'b1;
            second_d = 1'b0; // RULE_06
        end
        if (cmd_disarm) begin
            armed_d = 1'b0;
            run_d = 1'b0;
            retrig_d = 1'b0;
        end
        if (bus.wr && (bus.addr == CRM_ADDR_HOLD)) begin
            hold_d = bus.wdata;
        end
    end

    // =========================================================
    // State
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            hold_q <= 16'h0000;
            armed_q <= 1'b0;
            run_q <= 1'b0;
            second_q <= 1'b0;
            retrig_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            hold_q <= hold_d;
            armed_q <= armed_d;
            run_q <= run_d;
            second_q <= second_d;
            retrig_q <= retrig_d;
        end
    end

    // Mode writes are the host's duty to time while disarmed.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= CRM_MODE_RESET;
            load_q <= 16'h0000;
        end else begin
            if (bus.wr && (bus.addr == CRM_ADDR_MODE)) begin
                mode_q <= bus.wdata; // RULE_24
            end
            if (bus.wr && (bus.addr == CRM_ADDR_LOAD)) begin
                load_q <= bus.wdata;
            end
        end
    end

    // =========================================================
    // Outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tc_q <= 1'b0;
            tgl_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            tc_q <= at_tc;
            out_q <= tgl_sel ? (tgl_q ^ at_tc) : at_tc; // RULE_04
            if (at_tc) begin
                tgl_q <= ~tgl_q; // RULE_04
            end
        end
    end

    wire [15:0] stat_word = {13'h0000, second_q, run_q, armed_q};
    wire [15:0] rd_mux = (bus.addr == CRM_ADDR_MODE) ? mode_q :
                         (bus.addr == CRM_ADDR_LOAD) ? load_q :
                         (bus.addr == CRM_ADDR_HOLD) ? hold_q :
                         (bus.addr == CRM_ADDR_STAT) ? stat_word :
                         (bus.addr == CRM_ADDR_CNT) ? cnt_q : 16'h0000;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= bus.rd ? rd_mux : 16'h0000;
        end
    end

    assign rdata = rdata_q;
    assign terminal_count = tc_q;
    assign armed = armed_q;
    assign out_pin = out_q;

    // =========================================================
    // Checks
    property p_tc_pulse;
        @(posedge clk_sys) disable iff (!rst_n) at_tc |=> tc_q ##1 !tc_q;
    endproperty
    a_tc_pulse: assert property (p_tc_pulse) else $error("terminal count not from tc"); // RULE_23

    property p_strobe_disarm;
        @(posedge clk_sys) disable iff (!rst_n) (at_tc && op_strobe && !cmd_arm) |=> !armed_q;
    endproperty
    a_strobe_disarm: assert property (p_strobe_disarm) else $error("strobe did not disarm"); // RULE_11

    property p_alt_stays;
        @(posedge clk_sys) disable iff (!rst_n) (at_tc && op_alt && !cmd_disarm) |=> armed_q;
    endproperty
    a_alt_stays: assert property (p_alt_stays) else $error("alternating mode disarmed"); // RULE_02

    property p_alt_hold;
        @(posedge clk_sys) disable iff (!rst_n)
            (at_tc && op_alt && !second_q && !cmd_load) |=> cnt_q == $past(hold_q);
    endproperty
    a_alt_hold: assert property (p_alt_hold) else $error("first reload not from hold"); // RULE_03

    property p_save;
        @(posedge clk_sys) disable iff (!rst_n)
            (retrig_ev && !(bus.wr && bus.addr == CRM_ADDR_HOLD)) |=> hold_q == $past(cnt_q);
    endproperty
    a_save: assert property (p_save) else $error("retrigger did not save count"); // RULE_12

    property p_disarmed_edge;
        @(posedge clk_sys) disable iff (!rst_n) (!armed_q && !run_q) |=> !run_q;
    endproperty
    a_disarmed_edge: assert property (p_disarmed_edge) else $error("started while disarmed"); // RULE_10

    property p_retrig_load;
        @(posedge clk_sys) disable iff (!rst_n)
            (step && retrig_q && !cmd_load) |=> cnt_q == $past(load_q) && !retrig_q;
    endproperty
    a_retrig_load: assert property (p_retrig_load) else $error("retrigger load missing"); // RULE_13

    property p_level_hold;
        @(posedge clk_sys) disable iff (!rst_n)
            (gate_level && !gate_act && !cmd_load && !retrig_ev) |=> cnt_q == $past(cnt_q);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("counted with gate inactive"); // RULE_05

    property p_arm_first;
        @(posedge clk_sys) disable iff (!rst_n) cmd_arm |=> !second_q;
    endproperty
    a_arm_first: assert property (p_arm_first) else $error("arm did not restart alternation"); // RULE_06

    c_tc: cover property (@(posedge clk_sys) disable iff (!rst_n) at_tc && op_alt && second_q);
    c_retrig: cover property (@(posedge clk_sys) disable iff (!rst_n) retrig_ev ##[1:20] step);
    c_oneshot: cover property (@(posedge clk_sys) disable iff (!rst_n) trigger && op_sync && gate_edge);
endmodule

/* testbench/crm_pins_model.sv */
// Far-side model of the counter's source and gate pins.
// Assumes the bench drives en and gate just after clk_sys rises.
`timescale 1ns/10ps
module crm_pins_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control from the bench
    input wire logic en,
    input wire logic gate,
    // Pins
    output crm_pkg::crm_pins_type pins
);
    import crm_pkg::*;
    // The source toggles every cycle while enabled and rests low otherwise.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pins <= '0;
        end else begin
            pins.src <= en & ~pins.src;
            pins.gate <= gate;
        end
    end
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the counter: register port stimulus and pin model.
// Assumes one counter instance on a 25 MHz clk_sys.
`timescale 1ns/10ps
module tb_top;
    import crm_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    crm_bus_type bus = '0;
    logic en = 1'b0;
    logic gate = 1'b0;
    logic lvl = 1'b0;
    logic rd_q = 1'b0;
    logic src_p = 1'b0;
    logic tgl_on = 1'b0;
    logic tgl_e = 1'b0;
    crm_pins_type pins;
    logic [15:0] rdata;
    logic out_pin, terminal_count, armed;
    logic [15:0] cnt = '0;
    logic [15:0] ld, hd;
    logic [15:0] rq[$];
    logic [15:0] tq[$];
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 86342;
    wire rise = pins.src & ~src_p & (~lvl | pins.gate);
    always #20 clk_sys = ~clk_sys;
    crm_pins_model u_crm_pins_model (.clk_sys(clk_sys), .rst_n(rst_n), .en(en), .gate(gate), .pins(pins));
    crm_counter u_crm_counter (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdata(rdata), .pins(pins),
        .out_pin(out_pin), .terminal_count(terminal_count), .armed(armed));
    // ====================
    // Checking
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Each terminal count is paired with the counted source edges before it.
    always @(posedge clk_sys) begin
        if (rd_q) chk(rq.pop_front(), rdata);
        rd_q <= bus.rd;
        src_p <= pins.src;
        if (terminal_count) tgl_e <= ~tgl_e;
        if (tgl_on) chk(16'(tgl_e ^ terminal_count), 16'(out_pin));
        if (!terminal_count) begin
            cnt <= cnt + 16'(rise);
        end else if (tq.size() == 0) begin
            chk(16'h0, 16'h1);
        end else begin
            chk(tq.pop_front(), cnt);
            cnt <= 16'(rise);
        end
    end
    task automatic stop_test;
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200us;
        error_cnt++;
        stop_test;
    end
    // ====================
    // Drivers
    task automatic bus_op(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
        if (r) rq.push_back(d);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge clk_sys);
    endtask
    task automatic cmd(input logic [15:0] d);
        bus_op(1'b1, 1'b0, CRM_ADDR_CMD, d);
    endtask
    task automatic cfg(input logic [2:0] g, input logic [2:0] op, input logic up, input logic [15:0] l,
        input logic [15:0] h);
        cmd(16'h2);
        bus_op(1'b1, 1'b0, CRM_ADDR_MODE, {g, 5'h0, op, 1'b0, up, 2'h0, tgl_on});
        bus_op(1'b1, 1'b0, CRM_ADDR_LOAD, l);
        bus_op(1'b1, 1'b0, CRM_ADDR_HOLD, h);
        cmd(16'h4);
        cmd(16'h1);
    endtask
    task automatic run(input int n, input logic wig);
        bus <= '0;
        en <= 1'b1;
        repeat (2 * n) begin
            @(posedge clk_sys);
            if (wig) gate <= 1'($random(seed));
        end
        en <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(16'(tq.size()), 16'h0);
        tq.delete();
        @(negedge clk_sys);
        cnt = '0;
        @(posedge clk_sys);
    endtask
    // A rising gate edge with the source at rest.
    task automatic pulse;
        bus <= '0;
        gate <= 1'b0;
        repeat (2) @(posedge clk_sys);
        gate <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask
    // ====================
    // Scenarios
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        ld = 16'(2 + ($random(seed) & 3));
        hd = 16'(6 + ($random(seed) & 3));
        bus_op(1'b0, 1'b1, CRM_ADDR_MODE, CRM_MODE_RESET);
        bus_op(1'b0, 1'b1, 4'hf, 16'h0);
        tgl_on = 1'b1;
        cfg(CRM_GATE_NONE, CRM_OP_ALT, 1'b0, ld, hd);
        tq = '{ld, hd, ld, hd};
        run(2 * (ld + hd), 1'b1);
        tgl_on = 1'b0;
        cfg(CRM_GATE_NONE, CRM_OP_ALT, 1'b1, 16'hfffd, 16'hfffe);
        tq = '{16'h3, 16'h2};
        run(5, 1'b0);
        lvl = 1'b1;
        gate <= 1'b0;
        cfg(CRM_GATE_LVL_HI, CRM_OP_ALT, 1'b0, ld, hd);
        run(4, 1'b0);
        gate <= 1'b1;
        tq = '{ld};
        run(ld, 1'b0);
        cmd(16'h2);
        cmd(16'h1);
        tq = '{hd, hd, ld};
        run(2 * hd + ld, 1'b0);
        lvl = 1'b0;
        cfg(CRM_GATE_EDGE_HI, CRM_OP_ALT, 1'b0, ld, hd);
        cmd(16'h2);
        pulse;
        run(3, 1'b0);
        cmd(16'h1);
        pulse;
        tq = '{ld, hd};
        run(ld + hd + 3, 1'b0);
        pulse;
        tq = '{ld, hd};
        run(ld + hd, 1'b0);
        cfg(CRM_GATE_EDGE_HI, CRM_OP_STROBE, 1'b0, ld, hd);
        pulse;
        tq = '{ld + 16'h1};
        run(ld + 4, 1'b0);
        chk(16'(armed), 16'h0);
        bus_op(1'b0, 1'b1, CRM_ADDR_HOLD, ld);
        pulse;
        run(3, 1'b0);
        lvl = 1'b1;
        cfg(CRM_GATE_LVL_HI, CRM_OP_STROBE, 1'b0, ld, hd);
        pulse;
        tq = '{ld + 16'h1};
        run(ld + 3, 1'b0);
        chk(16'(armed), 16'h0);
        bus_op(1'b0, 1'b1, CRM_ADDR_HOLD, ld);
        lvl = 1'b0;
        cfg(CRM_GATE_EDGE_HI, CRM_OP_SYNC, 1'b0, ld, hd);
        pulse;
        tq = '{ld + 16'h1};
        run(ld + 4, 1'b0);
        chk(16'(armed), 16'h1);
        pulse;
        tq = '{ld + 16'h1};
        run(ld + 1, 1'b0);
        lvl = 1'b1;
        cfg(CRM_GATE_LVL_HI, CRM_OP_SYNC, 1'b0, ld, hd);
        pulse;
        tq = '{ld + 16'h1, ld, ld};
        run(3 * ld + 1, 1'b0);
        stop_test;
    end
endmodule
